// >>> rtl/smcr_pkg.sv
// Purpose: Shared constants for the synthesizer margining configuration register slice
// Assumes: APB byte addresses are four times the printed register index
// Notes: Settle times are kept in microseconds, counts derived from the always-on clock rate
package smcr_pkg;
   // Register indices as printed; byte address is four times these
   localparam logic [7:0] IDX_STEP8_HI = 8'h66;
   localparam logic [7:0] IDX_STEP8_LO = 8'h67;
   localparam logic [7:0] IDX_SOFT_HI = 8'h68;
   localparam logic [7:0] IDX_SOFT_LO = 8'h69;
   localparam logic [7:0] IDX_S1_PULSE = 8'h75;
   localparam logic [7:0] IDX_S1_FILTER = 8'h76;
   localparam logic [7:0] IDX_S1_SETTLE = 8'h77;
   localparam logic [7:0] IDX_S1_BW = 8'h78;
   localparam logic [7:0] IDX_S2_PULSE = 8'h83;
   localparam logic [7:0] IDX_S2_FILTER = 8'h84;
   localparam logic [7:0] IDX_S2_SETTLE = 8'h85;
   localparam logic [7:0] IDX_S2_BW = 8'h86;
   localparam logic [7:0] IDX_MARGIN_SEL = 8'h64;
   localparam logic [7:0] IDX_STATUS = 8'h90;
   // Reset values
   localparam logic [1:0] RST_STEP8_HI = 2'h2;
   localparam logic [7:0] RST_STEP8_LO = 8'h9E;
   localparam logic [1:0] RST_SOFT_HI = 2'h0;
   localparam logic [7:0] RST_SOFT_LO = 8'h00;
   localparam logic [2:0] RST_FILTER = 3'h3;
   localparam logic [1:0] RST_CLOSED = 2'h0;
   localparam logic [1:0] RST_VCO = 2'h1;
   localparam logic [1:0] RST_MARGIN_SEL = 2'h0;
   // Field positions
   localparam int POS_WIDEN = 7;
   localparam int POS_CLOSED = 2;
   localparam int POS_VCO = 0;
   localparam int POS_MARGIN_SEL = 2;
   // Filter codes and margin source code
   localparam logic [2:0] FILTER_SECOND = 3'h3;
   localparam logic [2:0] FILTER_THIRD = 3'h7;
   localparam logic [1:0] MARGIN_SRC_SOFT = 2'h2;
   // Settle times in microseconds and always-on clock rate in kHz
   localparam int AON_KHZ = 10000;
   localparam int CLOSED_US0 = 30;
   localparam int CLOSED_US1 = 300;
   localparam int CLOSED_US2 = 30000;
   localparam int CLOSED_US3 = 300000;
   localparam int VCO_US0 = 20;
   localparam int VCO_US1 = 400;
   localparam int VCO_US2 = 8000;
   localparam int VCO_US3 = 200000;
   localparam int WAIT_W = 32;
   // Microseconds to always-on clock periods, rounded up
   function automatic logic [31:0] us_to_cycles(input int us, input int khz);
      longint p;
      p = (longint'(us) * longint'(khz) + 64'd999) / 64'd1000;
      us_to_cycles = (p < 1) ? 32'd1 : p[31:0];
   endfunction
endpackage

// >>> rtl/smcr_settle_timer.sv
// Purpose: Settle wait counter for one synthesizer, clocked by the always-on clock
// Assumes: start is a one-cycle pulse; codes are stable while waiting
// Notes: A VCO wait is followed by the closed-loop wait; done pulses once at the end
`timescale 1ns/1ps
`default_nettype none
module smcr_settle_timer #(
   parameter int AON_KHZ = smcr_pkg::AON_KHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Control
   input wire logic start,
   input wire logic [1:0] closed_code,
   input wire logic [1:0] vco_code,
   // Status
   output logic busy,
   output logic done
);
   typedef enum logic [2:0] {
      SMCR_IDLE = 3'b001,
      SMCR_VCO = 3'b010,
      SMCR_CLOSED = 3'b100
   } smcr_tmr_t;

   smcr_tmr_t state_q;
   logic [31:0] count_q;

   function automatic logic [31:0] closed_len(input logic [1:0] c);
      case (c)
         2'h0: closed_len = smcr_pkg::us_to_cycles(smcr_pkg::CLOSED_US0, AON_KHZ);
         2'h1: closed_len = smcr_pkg::us_to_cycles(smcr_pkg::CLOSED_US1, AON_KHZ);
         2'h2: closed_len = smcr_pkg::us_to_cycles(smcr_pkg::CLOSED_US2, AON_KHZ);
         default: closed_len = smcr_pkg::us_to_cycles(smcr_pkg::CLOSED_US3, AON_KHZ);
      endcase
   endfunction

   function automatic logic [31:0] vco_len(input logic [1:0] c);
      case (c)
         2'h0: vco_len = smcr_pkg::us_to_cycles(smcr_pkg::VCO_US0, AON_KHZ);
         2'h1: vco_len = smcr_pkg::us_to_cycles(smcr_pkg::VCO_US1, AON_KHZ);
         2'h2: vco_len = smcr_pkg::us_to_cycles(smcr_pkg::VCO_US2, AON_KHZ);
         default: vco_len = smcr_pkg::us_to_cycles(smcr_pkg::VCO_US3, AON_KHZ);
      endcase
   endfunction

   // Two-phase wait: VCO settle then closed-loop settle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SMCR_IDLE;
         count_q <= 32'h0000_0000;
         done <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         case (state_q)
            SMCR_IDLE: begin
               if (start) begin
                  state_q <= SMCR_VCO;
                  count_q <= vco_len(vco_code) - 32'd1; // R8
               end
            end
            SMCR_VCO: begin
               if (count_q == 32'h0000_0000) begin
                  state_q <= SMCR_CLOSED;
                  count_q <= closed_len(closed_code) - 32'd1; // R6
               end else begin
                  count_q <= count_q - 32'd1;
               end
            end
            SMCR_CLOSED: begin
               if (count_q == 32'h0000_0000) begin
                  state_q <= SMCR_IDLE;
                  done <= 1'b1;
               end else begin
                  count_q <= count_q - 32'd1;
               end
            end
            default: state_q <= SMCR_IDLE;
         endcase
      end
   end

   // Busy is its own register, loaded from the next-state condition so it matches state_q != SMCR_IDLE
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (ce) begin
         busy <= (state_q == SMCR_IDLE) ? start : !(state_q == SMCR_CLOSED && count_q == 0);
      end
   end
endmodule
`default_nettype wire

// >>> rtl/smcr_regs.sv
// Purpose: Margining offset and dual synthesizer configuration registers over APB
// Assumes: 32-bit APB, byte address = 4 * register index, byte-wide data in bits 7:0
// Notes: Zero wait states; unmapped addresses read zero and raise pslverr
//
// Behaviour
// R1: The step-8 margin offset is a 10-bit value, upper two bits reset 2, lower byte reset 0x9E.
// R2: A software margin offset of 10 bits is writable in two registers, both resetting to zero.
// R3: With margin source select equal to 2 the applied offset is the software offset.
// R4: Each synthesizer has a pulse widen bit, 0 for about 200 ps and 1 for about 600 ps.
// R5: Each loop filter field selects second order at 3 (reset) and third order at 7, others reserved.
// R6: The closed-loop settle code waits 30 us, 300 us, 30 ms or 300 ms and resets to 0.
// R7: Software sets closed-loop settle to 1 for clock generator use and 3 for jitter cleaning.
// R8: The VCO settle code waits 20 us, 400 us, 8 ms or 200 ms and resets to 1.
// R9: A set narrow-bandwidth bit cuts loop bandwidth to 200 Hz, clear restores normal bandwidth.
// R10: Software changing the bandwidth bit also programs matching loop settings.
// R11: Both synthesizers keep separate copies of all fields and reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none
module smcr_regs #(
   parameter int AON_KHZ = smcr_pkg::AON_KHZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Margining
   input wire logic [9:0] margin_pin_offset,
   output logic [9:0] margin_applied_offset,
   output logic [9:0] margin_step8_offset,
   // First synthesizer
   output logic first_synth_pulse_widen,
   output logic [2:0] first_synth_filter_order,
   output logic first_synth_narrow_bandwidth,
   output logic first_synth_settled,
   // Second synthesizer
   output logic second_synth_pulse_widen,
   output logic [2:0] second_synth_filter_order,
   output logic second_synth_narrow_bandwidth,
   output logic second_synth_settled
);
   // Field storage; per-synthesizer arrays use index 0 = first, 1 = second
   logic [1:0] step8_hi_q;
   logic [7:0] step8_lo_q;
   logic [1:0] soft_hi_q;
   logic [7:0] soft_lo_q;
   logic [1:0] margin_sel_q;
   logic widen_q [2];
   logic [2:0] filter_q [2];
   logic [1:0] closed_q [2];
   logic [1:0] vco_q [2];
   logic narrow_q [2];
   logic [1:0] relock_q;
   logic [1:0] busy;
   logic [1:0] done;
   logic [1:0] settled_q;

   logic wr_en;
   logic rd_en;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic hit;
   logic [7:0] rbyte;

   // Index decode; low two address bits must be zero for an aligned word
   assign idx = paddr[9:2];
   assign wbyte = pwdata[7:0];
   assign wr_en = psel && penable && pwrite && pstrb[0] && hit && paddr[1:0] == 2'h0;
   assign rd_en = psel && penable && !pwrite;

   // Reserved filter codes are refused so the loop never sees an undefined order
   function automatic logic filter_ok(input logic [2:0] c);
      filter_ok = (c == smcr_pkg::FILTER_SECOND) || (c == smcr_pkg::FILTER_THIRD); // R5
   endfunction

   // Read mux; reserved bits return zero
   always_comb begin
      hit = 1'b1;
      rbyte = 8'h00;
      case (idx)
         smcr_pkg::IDX_STEP8_HI: rbyte = {6'h00, step8_hi_q}; // R1
         smcr_pkg::IDX_STEP8_LO: rbyte = step8_lo_q; // R1
         smcr_pkg::IDX_SOFT_HI: rbyte = {6'h00, soft_hi_q}; // R2
         smcr_pkg::IDX_SOFT_LO: rbyte = soft_lo_q; // R2
         smcr_pkg::IDX_MARGIN_SEL: rbyte = {4'h0, margin_sel_q, 2'h0};
         smcr_pkg::IDX_S1_PULSE: rbyte = {widen_q[0], 7'h00}; // R11
         smcr_pkg::IDX_S1_FILTER: rbyte = {5'h00, filter_q[0]};
         smcr_pkg::IDX_S1_SETTLE: rbyte = {4'h0, closed_q[0], vco_q[0]};
         smcr_pkg::IDX_S1_BW: rbyte = {7'h00, narrow_q[0]};
         smcr_pkg::IDX_S2_PULSE: rbyte = {widen_q[1], 7'h00}; // R11
         smcr_pkg::IDX_S2_FILTER: rbyte = {5'h00, filter_q[1]};
         smcr_pkg::IDX_S2_SETTLE: rbyte = {4'h0, closed_q[1], vco_q[1]};
         smcr_pkg::IDX_S2_BW: rbyte = {7'h00, narrow_q[1]};
         smcr_pkg::IDX_STATUS: rbyte = {4'h0, busy, settled_q};
         default: hit = 1'b0;
      endcase
      if (paddr[11:10] != 2'h0) begin
         hit = 1'b0;
         rbyte = 8'h00;
      end
   end

   // Margining offset registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step8_hi_q <= smcr_pkg::RST_STEP8_HI; // R1
         step8_lo_q <= smcr_pkg::RST_STEP8_LO; // R1
         soft_hi_q <= smcr_pkg::RST_SOFT_HI; // R2
         soft_lo_q <= smcr_pkg::RST_SOFT_LO; // R2
         margin_sel_q <= smcr_pkg::RST_MARGIN_SEL;
      end else if (ce && wr_en) begin
         case (idx)
            smcr_pkg::IDX_STEP8_HI: step8_hi_q <= wbyte[1:0]; // R1
            smcr_pkg::IDX_STEP8_LO: step8_lo_q <= wbyte; // R1
            smcr_pkg::IDX_SOFT_HI: soft_hi_q <= wbyte[1:0]; // R2
            smcr_pkg::IDX_SOFT_LO: soft_lo_q <= wbyte; // R2
            smcr_pkg::IDX_MARGIN_SEL: margin_sel_q <= wbyte[smcr_pkg::POS_MARGIN_SEL +: 2];
            default: ;
         endcase
      end
   end

   // Synthesizer controls, one copy per synthesizer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < 2; s++) begin
            widen_q[s] <= 1'b0; // R4
            filter_q[s] <= smcr_pkg::RST_FILTER; // R5
            closed_q[s] <= smcr_pkg::RST_CLOSED; // R6
            vco_q[s] <= smcr_pkg::RST_VCO; // R8
            narrow_q[s] <= 1'b0; // R9
         end
         relock_q <= 2'b11;
      end else if (ce) begin
         relock_q <= 2'b00;
         if (wr_en) begin
            case (idx)
               smcr_pkg::IDX_S1_PULSE: widen_q[0] <= wbyte[smcr_pkg::POS_WIDEN]; // R4
               smcr_pkg::IDX_S2_PULSE: widen_q[1] <= wbyte[smcr_pkg::POS_WIDEN]; // R4
               smcr_pkg::IDX_S1_FILTER: begin
                  if (filter_ok(wbyte[2:0])) begin
                     filter_q[0] <= wbyte[2:0]; // R5
                  end
               end
               smcr_pkg::IDX_S2_FILTER: begin
                  if (filter_ok(wbyte[2:0])) begin
                     filter_q[1] <= wbyte[2:0]; // R5
                  end
               end
               smcr_pkg::IDX_S1_SETTLE: begin
                  closed_q[0] <= wbyte[smcr_pkg::POS_CLOSED +: 2]; // R6
                  vco_q[0] <= wbyte[smcr_pkg::POS_VCO +: 2]; // R8
               end
               smcr_pkg::IDX_S2_SETTLE: begin
                  closed_q[1] <= wbyte[smcr_pkg::POS_CLOSED +: 2]; // R6
                  vco_q[1] <= wbyte[smcr_pkg::POS_VCO +: 2]; // R8
               end
               smcr_pkg::IDX_S1_BW: begin
                  narrow_q[0] <= wbyte[0]; // R9
                  relock_q[0] <= 1'b1; // R10
               end
               smcr_pkg::IDX_S2_BW: begin
                  narrow_q[1] <= wbyte[0]; // R9
                  relock_q[1] <= 1'b1; // R10
               end
               default: ;
            endcase
         end
      end
   end

   // Settle timers; a bandwidth write starts the wait only when the timer is idle (R11 keeps them separate)
   smcr_settle_timer #(.AON_KHZ(AON_KHZ)) u_tmr1 (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(relock_q[0]),
      .closed_code(closed_q[0]),
      .vco_code(vco_q[0]),
      .busy(busy[0]),
      .done(done[0])
   );

   smcr_settle_timer #(.AON_KHZ(AON_KHZ)) u_tmr2 (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(relock_q[1]),
      .closed_code(closed_q[1]),
      .vco_code(vco_q[1]),
      .busy(busy[1]),
      .done(done[1])
   );

   // Settled flags: set by timer end wins over the clear caused by a restart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settled_q <= 2'b00;
      end else if (ce) begin
         for (int s = 0; s < 2; s++) begin
            if (done[s]) begin
               settled_q[s] <= 1'b1; // R6
            end else if (relock_q[s]) begin
               settled_q[s] <= 1'b0;
            end
         end
      end
   end

   // Registered outputs to the analog side
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         margin_applied_offset <= 10'h000;
         margin_step8_offset <= {smcr_pkg::RST_STEP8_HI, smcr_pkg::RST_STEP8_LO};
         first_synth_pulse_widen <= 1'b0;
         first_synth_filter_order <= smcr_pkg::RST_FILTER;
         first_synth_narrow_bandwidth <= 1'b0;
         first_synth_settled <= 1'b0;
         second_synth_pulse_widen <= 1'b0;
         second_synth_filter_order <= smcr_pkg::RST_FILTER;
         second_synth_narrow_bandwidth <= 1'b0;
         second_synth_settled <= 1'b0;
      end else if (ce) begin
         if (margin_sel_q == smcr_pkg::MARGIN_SRC_SOFT) begin
            margin_applied_offset <= {soft_hi_q, soft_lo_q}; // R3
         end else begin
            margin_applied_offset <= margin_pin_offset;
         end
         margin_step8_offset <= {step8_hi_q, step8_lo_q}; // R1
         first_synth_pulse_widen <= widen_q[0]; // R4
         first_synth_filter_order <= filter_q[0]; // R5
         first_synth_narrow_bandwidth <= narrow_q[0]; // R9
         first_synth_settled <= settled_q[0];
         second_synth_pulse_widen <= widen_q[1]; // R4
         second_synth_filter_order <= filter_q[1]; // R5
         second_synth_narrow_bandwidth <= narrow_q[1]; // R9
         second_synth_settled <= settled_q[1];
      end
   end

   // APB answer: zero wait states, data and error registered in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && (!hit || paddr[1:0] != 2'h0);
         // A misaligned read reports an error and must not leak the neighbouring byte
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite && hit && paddr[1:0] == 2'h0) begin
            prdata <= {24'h000000, rbyte}; // R11
         end
      end
   end

   // Read strobe is not otherwise used; reads have no side effects
   logic unused_rd;
   assign unused_rd = rd_en;
endmodule
`default_nettype wire

// >>> tb/smcr_regs_chk.sv
// Purpose: Port-level checks for the margining and synthesizer register slice
// Assumes: ce stays high; byte address is four times the register index
// Notes: Bound onto smcr_regs; watches a subset of its ports
`timescale 1ns/1ps
`default_nettype none
module smcr_regs_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Configuration outputs
   input wire logic [9:0] margin_step8_offset,
   input wire logic first_synth_pulse_widen,
   input wire logic [2:0] first_synth_filter_order,
   input wire logic [2:0] second_synth_filter_order,
   input wire logic first_synth_narrow_bandwidth,
   input wire logic first_synth_settled
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Setup phase and a committed write to one address
   sequence s_setup;
      psel && !penable && ce;
   endsequence
   sequence s_wr(a);
      psel && penable && pready && ce && pwrite && pstrb[0] && paddr == a;
   endsequence
   a_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   // Register fields reach the ports one cycle after the write edge, so checks look two ahead
   a_bad_align: assert property ((psel && penable && pready && !pwrite && paddr[1:0] != 2'h0)
      |-> pslverr && prdata == 32'h0) else $error("misaligned read accepted");
   a_widen_wr: assert property (s_wr(12'h1D4) |-> ##2 first_synth_pulse_widen ==
      $past(pwdata[7], 2)) else $error("widen bit not written");
   a_step8_lo: assert property (s_wr(12'h19C) |-> ##2 margin_step8_offset[7:0] ==
      $past(pwdata[7:0], 2) && $stable(margin_step8_offset[9:8]))
      else $error("step8 low byte wrong");
   a_filter_legal: assert property (first_synth_filter_order inside {3'h3, 3'h7} &&
      second_synth_filter_order inside {3'h3, 3'h7}) else $error("filter code reserved");
   a_filter_keep: assert property (s_wr(12'h1D8) ##0 !(pwdata[2:0] inside {3'h3, 3'h7})
      |-> ##2 $stable(first_synth_filter_order)) else $error("reserved filter code taken");
   a_narrow_wr: assert property (s_wr(12'h1E0) |-> ##2 first_synth_narrow_bandwidth ==
      $past(pwdata[0], 2)) else $error("narrow bit not written");
   a_settle_restart: assert property (s_wr(12'h1E0) ##0 first_synth_settled
      |-> ##3 !first_synth_settled) else $error("settle wait not restarted");
endmodule
bind smcr_regs smcr_regs_chk u_smcr_regs_chk (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .margin_step8_offset(margin_step8_offset),
   .first_synth_pulse_widen(first_synth_pulse_widen),
   .first_synth_filter_order(first_synth_filter_order),
   .second_synth_filter_order(second_synth_filter_order),
   .first_synth_narrow_bandwidth(first_synth_narrow_bandwidth),
   .first_synth_settled(first_synth_settled));
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the margining and synthesizer register slice
// Assumes: Zero wait state APB slave; ce held high
// Notes: AON_KHZ is cut to 10 so settle waits stay short
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [3:0] pstrb = 4'hF, strb = 4'hF;
   logic pready, pslverr, w1, w2, n1, n2, s1, s2;
   logic [9:0] pin = 10'h000, applied, step8;
   logic [2:0] f1, f2;
   logic [33:0] expq[$];
   logic [33:0] e;
   logic [7:0] m[12];
   int seed = 32'h3590a664;
   int error_cnt = 0, total_checks = 0, cyc = 0;
   // Register byte addresses, reset values and implemented bits
   logic [11:0] ad[12] = '{12'h198, 12'h19C, 12'h1A0, 12'h1A4, 12'h1D4, 12'h1D8, 12'h1DC,
      12'h1E0, 12'h20C, 12'h210, 12'h214, 12'h218};
   logic [7:0] rv[12] = '{8'h02, 8'h9E, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00,
      8'h03, 8'h01, 8'h00};
   logic [7:0] mk[12] = '{8'h03, 8'hFF, 8'h03, 8'hFF, 8'h80, 8'h07, 8'h0F, 8'h01, 8'h80,
      8'h07, 8'h0F, 8'h01};
   smcr_regs #(.AON_KHZ(10)) u_smcr_regs (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .margin_pin_offset(pin),
      .margin_applied_offset(applied), .margin_step8_offset(step8),
      .first_synth_pulse_widen(w1), .first_synth_filter_order(f1),
      .first_synth_narrow_bandwidth(n1), .first_synth_settled(s1),
      .second_synth_pulse_widen(w2), .second_synth_filter_order(f2),
      .second_synth_narrow_bandwidth(n2), .second_synth_settled(s2));
   always #2.5 clk = ~clk;
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; the request is held until pready is sampled
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic er);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb;
      expq.push_back({!wr, er, wr ? 32'h0 : d});
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      // A transfer that never gets its answer counts against the run
      if (pready !== 1'b1) error_cnt++;
   endtask
   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Configuration ports against the register model
   task automatic chk_ports();
      check({13'h0, step8, w1, f1, n1, w2, f2, n2}, {13'h0, m[0][1:0], m[1], m[4][7],
         m[5][2:0], m[7][0], m[8][7], m[9][2:0], m[11][0]});
   endtask
   // Two edges first, so a restart has cleared the settled ports before they are looked at
   task automatic wait_settled(input int min_n);
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (!(s1 === 1'b1 && s2 === 1'b1) && n < 8000) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, s1, s2}, 33'h3);
      check({32'h0, n >= min_n}, 33'h1);
   endtask
   // Completion monitor takes the oldest note for every answered transfer
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (expq.size() == 0) check(33'h1, 33'h0);
         else begin
            e = expq.pop_front();
            check({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
         end
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values of the twelve listed registers and the configuration ports
      for (int i = 0; i < 12; i++) begin
         m[i] = rv[i];
         xfer(1'b0, ad[i], {24'h0, rv[i]}, 1'b0);
      end
      idle();
      chk_ports();
      $display("test reset values done");
      // Random full words; reserved bits must read zero, each synth holds its own copy
      for (int i = 0; i < 12; i++) begin
         r = $random(seed);
         if (i == 5 || i == 9) r[2:0] = r[3] ? 3'h7 : 3'h3;
         m[i] = r[7:0] & mk[i];
         xfer(1'b1, ad[i], r, 1'b0);
      end
      for (int i = 0; i < 12; i++) xfer(1'b0, ad[i], {24'h0, m[i]}, 1'b0);
      idle();
      chk_ports();
      $display("test random registers done");
      // Reserved filter codes, masked byte strobe, unmapped and misaligned places
      for (int c = 0; c < 7; c++) if (c != 3) xfer(1'b1, ad[5], c, 1'b0);
      xfer(1'b0, ad[5], {24'h0, m[5]}, 1'b0);
      strb = 4'hE;
      xfer(1'b1, ad[1], {24'h0, ~m[1]}, 1'b0);
      strb = 4'hF;
      xfer(1'b1, 12'h004, 32'hFFFF_FFFF, 1'b1);
      xfer(1'b0, 12'h004, 32'h0, 1'b1);
      xfer(1'b1, 12'h19D, 32'h0000_0055, 1'b1);
      xfer(1'b0, 12'h19D, 32'h0, 1'b1);
      xfer(1'b0, ad[1], {24'h0, m[1]}, 1'b0);
      idle();
      chk_ports();
      $display("test refusals done");
      // Margin source select: pins for codes 0, 1 and 3, software offset for code 2
      for (int s = 0; s < 4; s++) begin
         r = $random(seed);
         pin <= r[9:0];
         xfer(1'b1, 12'h190, s << 2, 1'b0);
         idle();
         repeat (2) @(posedge clk);
         check({23'h0, applied}, {23'h0, s == 2 ? {m[2][1:0], m[3]} : r[9:0]});
      end
      $display("test margin source done");
      // Clock generator then jitter cleaner set-up on each synth
      wait_settled(0);
      for (int j = 0; j < 9; j += 8) begin
         xfer(1'b1, ad[6 + j / 2 * 1], 32'h05, 1'b0);
         xfer(1'b1, ad[7 + j / 2 * 1], 32'h00, 1'b0);
         idle();
         // Closed loop 300 us plus VCO 400 us at 10 kHz: at least 7 cycles
         wait_settled(7);
         m[4 + j / 2] = 8'h80;
         m[5 + j / 2] = 8'h07;
         m[7 + j / 2] = 8'h01;
         xfer(1'b1, ad[4 + j / 2], 32'h80, 1'b0);
         xfer(1'b1, ad[5 + j / 2], 32'h07, 1'b0);
         xfer(1'b1, ad[6 + j / 2], 32'h0C, 1'b0);
         xfer(1'b1, ad[7 + j / 2], 32'h01, 1'b0);
         idle();
         // Closed loop 300 ms plus VCO 20 us at 10 kHz: at least 3001 cycles
         wait_settled(3001);
      end
      chk_ports();
      $display("test settle waits done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
